/* design/fosr_defines.svh */
`ifndef FOSR_DEFINES_SVH
`define FOSR_DEFINES_SVH
// apb register offsets (byte addresses)
`define FOSR_CTRL_OFF 12'h000
`define FOSR_STAT_OFF 12'h004
`define FOSR_POLL_OFF 12'h008
`define FOSR_OPSR_OFF 12'h00c
`define FOSR_ADDR_OFF 12'h010
// ctrl fields
`define FOSR_CTRL_GO 0
`define FOSR_CTRL_AUTO 1
// stat fields
`define FOSR_ST_BUSY 0
`define FOSR_ST_DONE 1
`define FOSR_ST_TMO 2
`define FOSR_ST_PROT 3
`define FOSR_ST_ABORT 4
`define FOSR_ST_ESUSP 5
`define FOSR_ST_RB 6
// polled data bit positions
`define FOSR_DP_BIT 7
`define FOSR_T1_BIT 6
`define FOSR_TO_BIT 5
`define FOSR_ET_BIT 3
`define FOSR_T2_BIT 2
`define FOSR_BA_BIT 1
// status register fields (bits 0 and 6 masked)
`define FOSR_SR_READY 7
`define FOSR_SR_ERASE 5
`define FOSR_SR_PROG 4
`define FOSR_SR_ABORT 3
`define FOSR_SR_PROT 1
`define FOSR_SR_MASK 8'hbe
// flash command codes and unlock addresses
`define FOSR_CMD_RESET 16'h00f0
`define FOSR_CMD_SRRD 16'h0070
`define FOSR_CMD_SRCLR 16'h0071
`define FOSR_CMD_UNL1 16'h00aa
`define FOSR_CMD_UNL2 16'h0055
`define FOSR_ADR_UNL1 24'h000555
`define FOSR_ADR_UNL2 24'h0002aa
// bus cycle width and post-reset busy allowance
`define FOSR_CYC_NS 100
`define FOSR_RSTBUSY_US 2
`define FOSR_CLK_NS 50
`endif

/* design/fosr_monitor.sv */
`timescale 1ns/1ps
`include "fosr_defines.svh"
// How it works
// RL1: timeout flag at one means failure
// RL2: write reset, wait out 2 us busy
// RL3: abort flag needs buffer abort reset
// RL4: erasing sector: toggles, timer one, busy
// RL5: outside erasing sector toggle two steady
// RL6: erase-suspended sector: polling one, ready
// RL7: other sectors give array data, ready
// RL8: suspend-program shows inverted bit seven
// RL9: never read suspended program line
// RL10: poll at a valid address
// RL11: device returns to prior mode
// RL12: error keeps device busy until cleared
// RL13: error polling: timeout one, timer one
// RL14: error status register: bit7, erase/program
// RL15: clear error by reset or clear
// RL16: protection busy 20 to 100 us
// RL17: protection: only status read accepted
// RL18: protection end raises ready line
// RL19: protection status register bit one set
// RL20: abort toggle two only in suspended sector
// RL21: abort: bits 7,4,3 set
// RL22: abort cleared by abort reset sequence
// RL23: toggle bit one toggles while busy
// RL24: mask reserved polled and status bits (only the status register is masked, polled data is kept raw)
module fosr_monitor #(
   parameter int CYC_CLKS = (`FOSR_CYC_NS + `FOSR_CLK_NS - 1) / `FOSR_CLK_NS,
   parameter int RSTBUSY_CLKS = (`FOSR_RSTBUSY_US * 1000 + `FOSR_CLK_NS - 1) / `FOSR_CLK_NS
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [15:0] dq_in,
   input wire logic ready_busy_in,
   output fosr_pkg::fosr_bus_t flash_out
);
   import fosr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: flash pins are not on our clock
   logic [15:0] dq_s1_r, dq_s2_r;
   logic rb_s1_r, rb_s2_r;
   always_ff @(posedge clk_sys_in) begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_in;
      rb_s2_r <= rb_s1_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // registers and state
   fosr_state_t state_r;
   logic [23:0] addr_r;
   logic auto_r, busy_r, done_r, tmo_r, prot_r, abort_r, esusp_r;
   logic [15:0] poll_r, first_r;
   logic [7:0] opsr_r;
   logic [7:0] cyc_r;
   logic [15:0] wait_r;
   logic [2:0] step_r;
   logic cyc_go_r, cyc_wr_r, cyc_end_r;
   logic [23:0] cyc_a_r;
   logic [15:0] cyc_d_r;

   // masked status register, reserved bits dropped
   function automatic logic [7:0] sr_mask(input logic [7:0] v);
      return v & `FOSR_SR_MASK; // RL24
   endfunction : sr_mask

   wire wr_acc = psel_in && penable_in && pwrite_in;
   wire go_w = wr_acc && paddr_in == `FOSR_CTRL_OFF && pwdata_in[`FOSR_CTRL_GO] && state_r == FOSR_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait, writes act at the access edge
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0;
         auto_r <= 1'b0;
         addr_r <= 24'h0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && paddr_in > `FOSR_ADDR_OFF;
         prdata_out <= 32'h0;
         if (psel_in && !penable_in && !pwrite_in) begin
            unique case (paddr_in)
               `FOSR_CTRL_OFF: prdata_out <= {30'h0, auto_r, 1'b0};
               `FOSR_STAT_OFF: prdata_out <= {25'h0, rb_s2_r, esusp_r, abort_r, prot_r, tmo_r, done_r, busy_r};
               `FOSR_POLL_OFF: prdata_out <= {16'h0, poll_r};
               `FOSR_OPSR_OFF: prdata_out <= {24'h0, opsr_r};
               `FOSR_ADDR_OFF: prdata_out <= {8'h0, addr_r};
               default: prdata_out <= 32'h0;
            endcase
         end
         if (wr_acc && paddr_in == `FOSR_CTRL_OFF) auto_r <= pwdata_in[`FOSR_CTRL_AUTO];
         if (wr_acc && paddr_in == `FOSR_ADDR_OFF) addr_r <= pwdata_in[23:0]; // RL10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flash bus cycle engine: one async read or write, cyc_clks + 2 wide strobe
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         flash_out <= '{addr: 24'h0, wdata: 16'h0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
         cyc_r <= 8'h0;
         cyc_end_r <= 1'b0;
      end else begin
         cyc_end_r <= 1'b0;
         if (cyc_go_r && cyc_r == 8'h0) begin
            flash_out <= '{addr: cyc_a_r, wdata: cyc_d_r, ce_n: 1'b0, oe_n: cyc_wr_r,
                           we_n: !cyc_wr_r, dq_oe: cyc_wr_r};
            cyc_r <= 8'(CYC_CLKS + 2); // two extra for the dq synchroniser
         end else if (cyc_r != 8'h0) begin
            cyc_r <= cyc_r - 8'h1;
            if (cyc_r == 8'h1) begin
               flash_out.ce_n <= 1'b1;
               flash_out.oe_n <= 1'b1;
               flash_out.we_n <= 1'b1;
               flash_out.dq_oe <= 1'b0;
               cyc_end_r <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status poll sequence: two reads, classify, read status reg, clear
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         state_r <= FOSR_IDLE;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         tmo_r <= 1'b0;
         prot_r <= 1'b0;
         abort_r <= 1'b0;
         esusp_r <= 1'b0;
         poll_r <= 16'h0;
         first_r <= 16'h0;
         opsr_r <= 8'h0;
         wait_r <= 16'h0;
         step_r <= 3'h0;
         cyc_go_r <= 1'b0;
         cyc_wr_r <= 1'b0;
         cyc_a_r <= 24'h0;
         cyc_d_r <= 16'h0;
      end else begin
         cyc_go_r <= 1'b0;
         unique case (state_r)
            FOSR_IDLE: if (go_w) begin
               busy_r <= 1'b1;
               done_r <= 1'b0;
               {tmo_r, prot_r, abort_r, esusp_r} <= 4'h0;
               cyc_a_r <= addr_r; // RL9 RL10
               cyc_wr_r <= 1'b0;
               cyc_go_r <= 1'b1;
               state_r <= FOSR_RD1;
            end
            FOSR_RD1: if (cyc_end_r) begin
               first_r <= dq_s2_r;
               cyc_go_r <= 1'b1;
               state_r <= FOSR_RD2;
            end
            FOSR_RD2: if (cyc_end_r) begin
               poll_r <= dq_s2_r;
               if (dq_s2_r[`FOSR_T1_BIT] == first_r[`FOSR_T1_BIT]) begin // RL23
                  // no toggle: either finished, or erase suspended (steady t1, t2 toggles)
                  esusp_r <= dq_s2_r[`FOSR_T2_BIT] != first_r[`FOSR_T2_BIT]; // RL6 RL7
                  state_r <= FOSR_DONE;
               end else if (dq_s2_r[`FOSR_TO_BIT] || dq_s2_r[`FOSR_BA_BIT] || !rb_s2_r) begin
                  // toggling: look at status register to tell error classes apart
                  tmo_r <= dq_s2_r[`FOSR_TO_BIT]; // RL1 RL13
                  // toggle two is don't-care while aborted, so it is not used to classify here
                  abort_r <= dq_s2_r[`FOSR_BA_BIT]; // RL3 RL21 RL20
                  cyc_a_r <= `FOSR_ADR_UNL1;
                  cyc_d_r <= `FOSR_CMD_SRRD; // RL17
                  cyc_wr_r <= 1'b1;
                  cyc_go_r <= 1'b1;
                  state_r <= FOSR_SRRD;
               end else begin
                  state_r <= FOSR_DONE; // RL4 RL5 RL8 still running
               end
            end
            FOSR_SRRD: if (cyc_end_r) begin
               cyc_wr_r <= 1'b0;
               cyc_go_r <= 1'b1;
               state_r <= FOSR_SRGET;
            end
            FOSR_SRGET: if (cyc_end_r) begin
               opsr_r <= sr_mask(dq_s2_r[7:0]); // RL14 RL21
               // protection: status not ready while the busy period runs
               prot_r <= !dq_s2_r[`FOSR_SR_READY] && !tmo_r && !abort_r; // RL16 RL19
               step_r <= 3'h0;
               if (auto_r && dq_s2_r[`FOSR_SR_READY] && (tmo_r || abort_r)) begin
                  state_r <= FOSR_CLR; // RL12 RL15
               end else begin
                  state_r <= FOSR_DONE; // RL18 no wait for ready to rise, done at once
               end
            end
            FOSR_CLR: if (step_r == 3'h0 || cyc_end_r) begin
               // abort needs the unlock-prefixed abort reset, timeout a plain reset
               cyc_wr_r <= 1'b1;
               cyc_go_r <= 1'b1;
               step_r <= step_r + 3'h1;
               if (abort_r && step_r == 3'h0) begin
                  cyc_a_r <= `FOSR_ADR_UNL1;
                  cyc_d_r <= `FOSR_CMD_UNL1; // RL22
               end else if (abort_r && step_r == 3'h1) begin
                  cyc_a_r <= `FOSR_ADR_UNL2;
                  cyc_d_r <= `FOSR_CMD_UNL2;
               end else if (abort_r && step_r == 3'h2) begin
                  cyc_a_r <= `FOSR_ADR_UNL1;
                  cyc_d_r <= `FOSR_CMD_RESET; // RL3
               end else if (step_r == 3'h0) begin
                  cyc_a_r <= 24'h0;
                  cyc_d_r <= `FOSR_CMD_RESET; // RL2
               end else begin
                  cyc_go_r <= 1'b0;
                  wait_r <= 16'(RSTBUSY_CLKS);
                  state_r <= FOSR_WAIT;
               end
            end
            FOSR_WAIT: begin
               // device may still show busy up to 2 us after the reset
               if (wait_r != 16'h0) wait_r <= wait_r - 16'h1; // RL2 RL11
               else state_r <= FOSR_DONE;
            end
            FOSR_DONE: begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
               state_r <= FOSR_IDLE;
            end
            default: state_r <= FOSR_IDLE;
         endcase
      end
   end
endmodule : fosr_monitor

/* design/fosr_pkg.sv */
package fosr_pkg;
   typedef enum logic [3:0] {
      FOSR_IDLE = 4'h0, FOSR_RD1 = 4'h1, FOSR_RD2 = 4'h3, FOSR_SRRD = 4'h2,
      FOSR_SRGET = 4'h6, FOSR_CLR = 4'h7, FOSR_WAIT = 4'h5, FOSR_DONE = 4'h4
   } fosr_state_t;
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe;
   } fosr_bus_t;
endpackage : fosr_pkg

/* tb/fosr_chk_monitor.sv */
`timescale 1ns/1ps
module fosr_chk_monitor #(
   parameter int CYC_CLKS = 2,
   parameter int RSTBUSY_CLKS = 40
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [15:0] dq_in,
   input wire logic ready_busy_in,
   input wire fosr_pkg::fosr_bus_t flash_out
);
   import fosr_pkg::*;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   ////////////////////////////////////////////////////////////////
   a_setup_answer: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no answer after setup");
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   a_unmapped_err: assert property (pready_out |-> pslverr_out == (paddr_in > 12'h010))
      else $error("error flag wrong");
   a_err_zero: assert property (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
      else $error("refused read not zero");
   a_status_masked: assert property (pready_out && !pwrite_in && paddr_in == 12'h00c
      |-> !prdata_out[0] && !prdata_out[6])
      else $error("reserved status bits seen");
   a_cycle_len: assert property ($fell(flash_out.ce_n) |-> !flash_out.ce_n [*4] ##1 flash_out.ce_n)
      else $error("flash cycle length wrong");
   a_addr_held: assert property (!flash_out.ce_n && !$past(flash_out.ce_n) |-> $stable(flash_out.addr))
      else $error("address moved in cycle");
   a_write_strobe: assert property (!flash_out.we_n |-> !flash_out.ce_n && flash_out.oe_n && flash_out.dq_oe)
      else $error("bad command write");
   c_write: cover property ($fell(flash_out.we_n));
   c_refused: cover property (pready_out && pslverr_out);
   c_opsr: cover property (pready_out && paddr_in == 12'h00c);
endmodule : fosr_chk_monitor

bind fosr_monitor fosr_chk_monitor #(.CYC_CLKS(CYC_CLKS), .RSTBUSY_CLKS(RSTBUSY_CLKS)) u_chk (
   .clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .dq_in(dq_in), .ready_busy_in(ready_busy_in),
   .flash_out(flash_out));

/* tb/fosr_flash_model.sv */
`timescale 1ns/1ps
module fosr_flash_model (
   input wire logic clk_sys_in,
   input wire fosr_pkg::fosr_bus_t bus_in,
   input wire logic [1:0] err_in,
   input wire logic load_in,
   output logic [15:0] dq_out,
   output logic ready_busy_out
);
   import fosr_pkg::*;
   logic [1:0] err_r = 2'h0; // 0 none, 1 timeout, 2 buffer abort
   logic tog_r = 1'b0;
   logic srmode_r = 1'b0;
   logic oe_q = 1'b1;
   logic we_q = 1'b1;
   logic [15:0] last_r = 16'h0;
   logic [7:0] word;
   // busy pin stays low until the host clears the error
   assign ready_busy_out = (err_r == 2'h0);
   // released bus shows the inverse so a stale value never passes
   assign dq_out = bus_in.oe_n ? ~last_r : last_r;
   ////////////////////////////////////////////////////////////////
   // overlaid status word, program flavour, loaded bit 7 was one; kind 3 is a protection busy period
   always_comb begin
      if (srmode_r) word = (err_r == 2'h1) ? 8'h90 : ((err_r == 2'h2) ? 8'h98 : 8'h00);
      else if (err_r != 2'h0) word = {1'b0, tog_r, err_r == 2'h1, 2'b01, tog_r, err_r == 2'h2, 1'b0};
      else word = 8'h34; // finished: bit 6 steady
   end
   // each read cycle flips the toggle bits; command writes act on we rise
   always @(posedge clk_sys_in) begin
      oe_q <= bus_in.oe_n;
      we_q <= bus_in.we_n;
      if (load_in) err_r <= err_in;
      if (!bus_in.oe_n && oe_q) begin
         last_r <= {8'h12, word};
         tog_r <= ~tog_r;
         srmode_r <= 1'b0;
      end
      if (bus_in.we_n && !we_q && bus_in.wdata == 16'h0070) srmode_r <= 1'b1;
      if (bus_in.we_n && !we_q && bus_in.wdata == 16'h00f0) err_r <= 2'h0;
   end
endmodule : fosr_flash_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "fosr_defines.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
   $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb_top;
   import fosr_pkg::*;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ld = 1'b0, pready, pslverr, rb, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] dq;
   logic [1:0] mode = 2'h0;
   logic [31:0] exp_sr [4] = '{32'h0, 32'h90, 32'h98, 32'h0};
   logic [23:0] ra;
   fosr_bus_t fbus;
   int fail_count = 0, comparisons = 0, cyc = 0, seed = 70, n;
   always #25 clk_sys_in = ~clk_sys_in;
   fosr_monitor #(.RSTBUSY_CLKS(4)) u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .dq_in(dq), .ready_busy_in(rb), .flash_out(fbus));
   fosr_flash_model u_flash (.clk_sys_in(clk_sys_in), .bus_in(fbus), .err_in(mode), .load_in(ld),
      .dq_out(dq), .ready_busy_out(rb));
   ////////////////////////////////////////////////////////////////
   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // one apb transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      // no wait count assumed: only the bench timeout ends a missing answer
      do begin @(posedge clk_sys_in); end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // a hang counts as a mismatch
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 30000) begin fail_count++; summarize(); end
   end
   // each fault kind in turn, then a refused address
   initial begin
      repeat (5) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      apb(1'b0, `FOSR_STAT_OFF, 32'h0);
      `CHK("stat", 6'h00, rd[5:0])
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys_in);
         mode <= m[1:0];
         ld <= 1'b1;
         @(posedge clk_sys_in);
         ld <= 1'b0;
         ra = 24'($random(seed));
         apb(1'b1, `FOSR_ADDR_OFF, {8'h00, ra});
         apb(1'b1, `FOSR_CTRL_OFF, 32'h3);
         n = 0;
         do begin apb(1'b0, `FOSR_STAT_OFF, 32'h0); n++; end while (rd[`FOSR_ST_BUSY] !== 1'b0 && n < 400);
         `CHK("done", 1'b1, rd[`FOSR_ST_DONE])
         `CHK("timeout", m == 1, rd[`FOSR_ST_TMO])
         `CHK("abort", m == 2, rd[`FOSR_ST_ABORT])
         `CHK("prot", m == 3, rd[`FOSR_ST_PROT])
         `CHK("ready", m != 3, rd[`FOSR_ST_RB])
         apb(1'b0, `FOSR_ADDR_OFF, 32'h0);
         `CHK("addr", {8'h00, ra}, rd)
         if (m == 0) begin
            apb(1'b0, `FOSR_POLL_OFF, 32'h0);
            `CHK("poll", 16'h1234, rd[15:0])
         end else begin
            apb(1'b0, `FOSR_OPSR_OFF, 32'h0);
            `CHK("opsr", exp_sr[m], rd)
         end
         $display("fault kind %0d finished", m);
      end
      apb(1'b0, 12'h014, 32'h0);
      `CHK("slverr", 1'b1, er)
      `CHK("rdata", 32'h0, rd)
      summarize();
   end
endmodule : tb_top
